// ---- cfg_pkg.sv ----
// package: register map, fields, reset values and timing for switch logic
package cfg_pkg;

  // register byte offsets
  localparam logic [3:0] status1_off    = 4'h0;
  localparam logic [3:0] switch_raw_off = 4'h4;
  localparam logic [3:0] ctrl_off       = 4'h8;
  localparam logic [3:0] geo_off        = 4'hc;

  // status1 fields
  localparam int safe_env_bit    = 5;
  localparam int boot_b_bit      = 0;
  localparam int bank_lock_bit   = 1;
  localparam int master_wp_bit   = 2;
  localparam int pass_thru_bit   = 3;
  localparam int low_offset_bit  = 4;
  localparam int fast_mezz_bit   = 6;
  localparam int sys_ctrl_bit    = 7;

  // control register fields (software write enables)
  localparam int nor_we_bit      = 0;
  localparam int nand_we_bit     = 1;
  localparam int mram_we_bit     = 2;
  localparam int eeprom_we_bit   = 3;

  // geographical address register fields
  localparam int geo_addr_lsb    = 0;
  localparam int geo_parity_bit  = 5;
  localparam int geo_source_bit  = 8;

  // reset values
  localparam logic [7:0] switch_rst  = 8'h00;
  localparam logic [3:0] ctrl_rst    = 4'h0;
  localparam logic [5:0] geo_sw_rst  = 6'h3f;
  localparam logic [31:0] unmapped_data = 32'h0000_0000;

  // clock rate and debounce time
  localparam int clk_hz          = 10_000_000;
  localparam int debounce_us     = 1000;
  localparam int debounce_cycles =
    (debounce_us * (clk_hz / 1_000_000) < 1) ? 1 :
    debounce_us * (clk_hz / 1_000_000);

  // mezzanine clock ceilings in MHz
  localparam logic [7:0] mezz_slow_mhz = 8'd100;
  localparam logic [7:0] mezz_fast_mhz = 8'd133;

  typedef enum logic [1:0] {
    db_idle   = 2'b00,
    db_settle = 2'b01,
    db_commit = 2'b11
  } debounce_state_t;

endpackage : cfg_pkg

// ---- switch_debounce.sv ----
// one switch line: two-flop synchroniser and stable-time debounce
`timescale 1ns/100ps
module switch_debounce #(
  parameter int          settle_cycles = cfg_pkg::debounce_cycles,
  parameter logic        rst_level     = 1'b0
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // raw switch level and its settled copy
  input  wire logic raw_in,
  output logic      level_out
);

  logic                        sync1_reg;
  logic                        sync2_reg;
  logic                        cand_reg;
  logic [23:0]                 count_reg;
  cfg_pkg::debounce_state_t    state_reg;
  cfg_pkg::debounce_state_t    state_next;
  logic                        level_reg;
  wire                         changed = sync2_reg != cand_reg;
  wire                         done    =
    count_reg == 24'(settle_cycles - 1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= rst_level;
      sync2_reg <= rst_level;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cfg_pkg::db_idle:   if (sync2_reg != level_reg) begin
        state_next = cfg_pkg::db_settle;
      end
      cfg_pkg::db_settle: if (changed) begin
        state_next = cfg_pkg::db_idle;
      end else if (done) begin
        state_next = cfg_pkg::db_commit;
      end
      default:            state_next = cfg_pkg::db_idle;
    endcase
  end

  // a level must hold settle_cycles before it is accepted
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= cfg_pkg::db_idle;
      cand_reg  <= rst_level;
      count_reg <= 24'h00_0000;
      level_reg <= rst_level;
    end else begin
      state_reg <= state_next;
      cand_reg  <= sync2_reg;
      if (state_reg != cfg_pkg::db_settle || changed) begin
        count_reg <= 24'h00_0000;
      end else begin
        count_reg <= count_reg + 24'h00_0001;
      end
      if (state_reg == cfg_pkg::db_commit) begin
        level_reg <= cand_reg;
      end
    end
  end

  assign level_out = level_reg;

endmodule : switch_debounce

// ---- board_config_switch_logic.sv ----
// board configuration switch logic with avalon-mm register slave
// Notes on behaviour
// R1: all switches except the address and parity switches read as off after reset; safe switch on forces safe values.
// R2: the safe switch level is readable at bit 5 of status register one.
// R3: boot switch off keeps normal map with block a, on maps block b on top.
// R4: bank lock on blocks every write to the code nor flash in hardware.
// R5: master protect on blocks all non-volatile writes whatever else is set.
// R6: master protect off leaves writes to the lock switch and software bits.
// R7: mezzanine clock ceiling is 100 MHz with switch off and 133 MHz with on.
// R8: installer keeps the mezzanine switch off unless all modules allow 133 MHz.
// R9: scan switch on puts the boundary-scan chain into pass-through routing.
// R10: low offset switch on enables the second-core low memory offset.
// R11: manual select off gives automatic controller role, on uses force select.
// R12: force select chooses role only under manual select, off means not.
// R13: without backplane address, address and parity come from switches.
// R14: the resulting geographical address is readable by software.
// R15: every switch is synchronised and debounced before use.
`timescale 1ns/100ps
module board_config_switch_logic (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // configuration switch bank one, position order as fitted
  input  wire logic        safe_env_sw,
  input  wire logic        boot_block_b_sw,
  input  wire logic        bank_lock_sw,
  input  wire logic        scan_pass_thru_sw,
  input  wire logic        second_core_low_offset_sw,
  input  wire logic        fast_mezz_sw,
  input  wire logic        master_wp_sw,
  // switch bank two
  input  wire logic        controller_manual_select,
  input  wire logic        controller_force_select,
  input  wire logic        geo_addr_parity_sw,
  input  wire logic [4:0]  geo_addr_sw,
  // backplane geographical address and automatic role detect
  input  wire logic        bp_geo_valid,
  input  wire logic [4:0]  bp_geo_addr,
  input  wire logic        bp_geo_parity,
  input  wire logic        auto_controller_detect,
  // non-volatile write requests from the board
  input  wire logic        nor_write_req,
  input  wire logic        nand_write_req,
  input  wire logic        mram_write_req,
  input  wire logic        eeprom_write_req,
  // effects
  output logic             use_safe_env,
  output logic             boot_block_b,
  output logic             nor_write_en,
  output logic             nand_write_en,
  output logic             mram_write_en,
  output logic             eeprom_write_en,
  output logic             scan_pass_thru,
  output logic             second_core_low_offset,
  output logic [7:0]       mezz_max_mhz,
  output logic             system_controller_role,
  output logic [4:0]       geo_addr,
  output logic             geo_addr_parity
);

  ////////////////////////////////////////////////////////////////////////////
  // switch conditioning

  localparam int n_sw = 15;
  wire  [n_sw-1:0] raw_sw = {geo_addr_parity_sw, geo_addr_sw,
                             controller_force_select,
                             controller_manual_select, master_wp_sw,
                             fast_mezz_sw, second_core_low_offset_sw,
                             scan_pass_thru_sw, bank_lock_sw,
                             boot_block_b_sw, safe_env_sw};
  logic [n_sw-1:0] sw;

  // address and parity switches rest at one, all others at off
  genvar gi;
  generate
    for (gi = 0; gi < n_sw; gi++) begin : g_sw
      switch_debounce #(
        .settle_cycles (cfg_pkg::debounce_cycles),
        .rst_level     (gi >= 9)
      ) u_db (
        .clock     (clock),
        .nrst      (nrst),
        .raw_in    (raw_sw[gi]),
        .level_out (sw[gi])
      ); // R15 R1 R13
    end
  endgenerate

  wire       s_safe   = sw[0];
  wire       s_boot   = sw[1];
  wire       s_lock   = sw[2];
  wire       s_pass   = sw[3];
  wire       s_low    = sw[4];
  wire       s_fast   = sw[5];
  wire       s_mwp    = sw[6];
  wire       s_man    = sw[7];
  wire       s_force  = sw[8];
  wire [4:0] s_geo    = sw[13:9];
  wire       s_gpar   = sw[14];

  ////////////////////////////////////////////////////////////////////////////
  // effects

  logic [3:0] ctrl_reg;
  logic       auto_sync1_reg;
  logic       auto_sync2_reg;

  function automatic logic gate_write(input logic req, input logic sw_en,
                                      input logic lock, input logic mwp);
    gate_write = req && sw_en && !lock && !mwp;
  endfunction : gate_write

  wire nor_next  = gate_write(nor_write_req,
    ctrl_reg[cfg_pkg::nor_we_bit], s_lock, s_mwp); // R4 R5 R6
  wire nand_next = gate_write(nand_write_req,
    ctrl_reg[cfg_pkg::nand_we_bit], 1'b0, s_mwp); // R5 R6
  wire mram_next = gate_write(mram_write_req,
    ctrl_reg[cfg_pkg::mram_we_bit], 1'b0, s_mwp); // R5 R6
  wire eep_next  = gate_write(eeprom_write_req,
    ctrl_reg[cfg_pkg::eeprom_we_bit], 1'b0, s_mwp); // R5 R6
  wire role_next = s_man ? s_force : auto_sync2_reg; // R11 R12
  wire [4:0] geo_next  = bp_geo_valid ? bp_geo_addr : s_geo; // R13
  wire       gpar_next = bp_geo_valid ? bp_geo_parity : s_gpar; // R13
  wire [7:0] mhz_next  =
    s_fast ? cfg_pkg::mezz_fast_mhz : cfg_pkg::mezz_slow_mhz; // R7

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      auto_sync1_reg <= 1'b0;
      auto_sync2_reg <= 1'b0;
    end else begin
      auto_sync1_reg <= auto_controller_detect;
      auto_sync2_reg <= auto_sync1_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      use_safe_env           <= 1'b0;
      boot_block_b           <= 1'b0;
      nor_write_en           <= 1'b0;
      nand_write_en          <= 1'b0;
      mram_write_en          <= 1'b0;
      eeprom_write_en        <= 1'b0;
      scan_pass_thru         <= 1'b0;
      second_core_low_offset <= 1'b0;
      mezz_max_mhz           <= cfg_pkg::mezz_slow_mhz;
      system_controller_role <= 1'b0;
      geo_addr               <= cfg_pkg::geo_sw_rst[4:0];
      geo_addr_parity        <= cfg_pkg::geo_sw_rst[5];
    end else begin
      use_safe_env           <= s_safe; // R1
      boot_block_b           <= s_boot; // R3
      nor_write_en           <= nor_next; // R4 R5
      nand_write_en          <= nand_next; // R5
      mram_write_en          <= mram_next; // R5
      eeprom_write_en        <= eep_next; // R5
      scan_pass_thru         <= s_pass; // R9
      second_core_low_offset <= s_low; // R10
      mezz_max_mhz           <= mhz_next; // R7
      system_controller_role <= role_next; // R11 R12
      geo_addr               <= geo_next; // R13
      geo_addr_parity        <= gpar_next; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, answer on the second edge

  logic        busy_reg;
  wire         req      = read || write;
  wire         take     = req && busy_reg;
  wire         hit_stat = address == cfg_pkg::status1_off;
  wire         hit_raw  = address == cfg_pkg::switch_raw_off;
  wire         hit_ctrl = address == cfg_pkg::ctrl_off;
  wire         hit_geo  = address == cfg_pkg::geo_off;
  wire [31:0]  stat_word;
  wire [31:0]  geo_word;
  wire [31:0]  rd_next;

  assign stat_word = 32'(
    (32'(s_safe) << cfg_pkg::safe_env_bit) | // R2
    (32'(s_boot) << cfg_pkg::boot_b_bit) |
    (32'(s_lock) << cfg_pkg::bank_lock_bit) |
    (32'(s_mwp)  << cfg_pkg::master_wp_bit) |
    (32'(s_pass) << cfg_pkg::pass_thru_bit) |
    (32'(s_low)  << cfg_pkg::low_offset_bit) |
    (32'(s_fast) << cfg_pkg::fast_mezz_bit) |
    (32'(system_controller_role) << cfg_pkg::sys_ctrl_bit));
  assign geo_word = 32'(
    (32'(geo_addr) << cfg_pkg::geo_addr_lsb) | // R14
    (32'(geo_addr_parity) << cfg_pkg::geo_parity_bit) |
    (32'(bp_geo_valid) << cfg_pkg::geo_source_bit));
  assign rd_next =
    hit_stat ? stat_word :
    hit_raw  ? {17'h0_0000, sw} :
    hit_ctrl ? {28'h000_0000, ctrl_reg} :
    hit_geo  ? geo_word : cfg_pkg::unmapped_data;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_reg    <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      ctrl_reg    <= cfg_pkg::ctrl_rst;
    end else begin
      busy_reg    <= req && !busy_reg;
      waitrequest <= !(req && !busy_reg);
      if (req && !busy_reg && read) begin
        readdata <= rd_next;
      end
      if (take && write && hit_ctrl && byteenable[0]) begin
        ctrl_reg <= writedata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_master_wp;
    @(posedge clock) disable iff (!nrst)
    s_mwp |=> !nor_write_en && !nand_write_en && !mram_write_en
              && !eeprom_write_en;
  endproperty
  a_master_wp: assert property (p_master_wp) // R5
    else $error("write enabled under master protect");

  property p_bank_lock;
    @(posedge clock) disable iff (!nrst)
    s_lock |=> !nor_write_en;
  endproperty
  a_bank_lock: assert property (p_bank_lock) // R4
    else $error("nor write enabled under bank lock");

  property p_write_allowed;
    @(posedge clock) disable iff (!nrst)
    !s_mwp && !s_lock && ctrl_reg[cfg_pkg::nor_we_bit] && nor_write_req
    |=> nor_write_en;
  endproperty
  a_write_allowed: assert property (p_write_allowed) // R6
    else $error("permitted nor write not enabled");

  property p_mezz;
    @(posedge clock) disable iff (!nrst)
    ##1 mezz_max_mhz == ($past(s_fast) ? cfg_pkg::mezz_fast_mhz
                                       : cfg_pkg::mezz_slow_mhz);
  endproperty
  a_mezz: assert property (p_mezz) // R7
    else $error("mezzanine ceiling wrong");

  property p_role;
    @(posedge clock) disable iff (!nrst)
    s_man |=> system_controller_role == $past(s_force);
  endproperty
  a_role: assert property (p_role) // R11 R12
    else $error("manual role not followed");

  property p_geo;
    @(posedge clock) disable iff (!nrst)
    !bp_geo_valid |=> geo_addr == $past(s_geo)
                      && geo_addr_parity == $past(s_gpar);
  endproperty
  a_geo: assert property (p_geo) // R13
    else $error("switch address not used");

  property p_safe_status;
    @(posedge clock) disable iff (!nrst)
    read && hit_stat && !busy_reg |=>
      readdata[cfg_pkg::safe_env_bit] == $past(s_safe);
  endproperty
  a_safe_status: assert property (p_safe_status) // R2
    else $error("safe status bit wrong");

  property p_geo_status;
    @(posedge clock) disable iff (!nrst)
    read && hit_geo && !busy_reg |=>
      readdata[5:0] == {$past(geo_addr_parity), $past(geo_addr)};
  endproperty
  a_geo_status: assert property (p_geo_status) // R14
    else $error("geo status word wrong");

  property p_boot;
    @(posedge clock) disable iff (!nrst)
    $rose(s_boot) |=> boot_block_b ##1 boot_block_b == $past(s_boot);
  endproperty
  a_boot: assert property (p_boot) // R3
    else $error("boot block select lag");

  property p_wait;
    @(posedge clock) disable iff (!nrst)
    req && !busy_reg |=> !waitrequest ##1 waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus answer timing wrong");

  c_safe:  cover property (@(posedge clock) disable iff (!nrst) $rose(s_safe));
  c_mwp:   cover property (@(posedge clock) disable iff (!nrst)
                           nor_write_req && s_mwp);
  c_write: cover property (@(posedge clock) disable iff (!nrst)
                           take && write && hit_ctrl);
  c_force: cover property (@(posedge clock) disable iff (!nrst)
                           s_man && s_force);

endmodule : board_config_switch_logic

// ---- board_config_switch_logic_bench.sv ----
// self-checking bench for the board configuration switch logic
`timescale 1ns/100ps
module board_config_switch_logic_bench;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [3:0] req;
    logic [3:0] en;
  } we_row_t;

  logic        clock;
  logic        nrst;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [6:0]  sw1;
  logic [7:0]  sw2;
  logic        bp_valid;
  logic [5:0]  bp_geo;
  logic        auto_det;
  logic [3:0]  req;
  logic [3:0]  en;
  logic [4:0]  fx;
  logic [7:0]  mezz;
  logic [4:0]  geo;
  logic        gpar;
  logic [31:0] rd;
  logic        seen_on;
  int          err_total;
  int          check_count;
  // software enable and request against the expected write enables
  we_row_t     rows [6] = '{12'hfff, 12'h0f0, 12'hf00, 12'h5f5, 12'ha32,
                            12'h111};

  board_config_switch_logic board_config_switch_logic_i (
    .clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .safe_env_sw(sw1[0]), .boot_block_b_sw(sw1[1]),
    .bank_lock_sw(sw1[2]), .scan_pass_thru_sw(sw1[3]),
    .second_core_low_offset_sw(sw1[4]), .fast_mezz_sw(sw1[5]),
    .master_wp_sw(sw1[6]), .controller_manual_select(sw2[0]),
    .controller_force_select(sw2[1]), .geo_addr_parity_sw(sw2[2]),
    .geo_addr_sw(sw2[7:3]), .bp_geo_valid(bp_valid),
    .bp_geo_addr(bp_geo[4:0]), .bp_geo_parity(bp_geo[5]),
    .auto_controller_detect(auto_det), .nor_write_req(req[0]),
    .nand_write_req(req[1]), .mram_write_req(req[2]),
    .eeprom_write_req(req[3]), .use_safe_env(fx[4]),
    .boot_block_b(fx[3]), .nor_write_en(en[0]), .nand_write_en(en[1]),
    .mram_write_en(en[2]), .eeprom_write_en(en[3]),
    .scan_pass_thru(fx[2]), .second_core_low_offset(fx[1]),
    .mezz_max_mhz(mezz), .system_controller_role(fx[0]),
    .geo_addr(geo), .geo_addr_parity(gpar)
  );

  initial clock = 1'b0;
  always #50 clock = ~clock;

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clock);
    read       <= ~wr;
    write      <= wr;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50) check("waitrequest", 32'h0000_0001, 32'h0000_0000);
  endtask : bus

  // full debounce span plus synchroniser and output stages
  task automatic settle();
    repeat (cfg_pkg::debounce_cycles + 20) @(posedge clock);
  endtask : settle

  task automatic wr_ctrl_req(input logic [3:0] c, input logic [3:0] r);
    bus(1'b1, cfg_pkg::ctrl_off, 32'(c), 4'hf);
    req <= r;
    repeat (3) @(posedge clock);
  endtask : wr_ctrl_req

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #(60_000 * 100);
    err_total++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
    sw1 = 7'h00;
    sw2 = 8'hfc;
    bp_valid = 1'b0;
    bp_geo = 6'h00;
    auto_det = 1'b0;
    req = 4'h0;
    err_total = 0;
    check_count = 0;
    repeat (4) @(posedge clock);
    check("effects", {fx, en}, 32'h0000_0000);
    check("mezz", mezz, 32'h0000_0064);
    check("geo", {gpar, geo}, 32'h0000_003f);
    check("waitrequest", waitrequest, 32'h0000_0001);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr_ctrl_req(rows[i].ctrl, rows[i].req);
      check("write_en", en, rows[i].en);
    end
    // byte lane 0 off must leave the control bits alone
    bus(1'b1, cfg_pkg::ctrl_off, 32'h0000_000f, 4'h0);
    bus(1'b0, cfg_pkg::ctrl_off, 32'h0000_0000, 4'hf);
    check("ctrl", rd, 32'h0000_0001);
    bus(1'b0, 4'h2, 32'h0000_0000, 4'hf);
    check("unmapped", rd, 32'h0000_0000);
    bus(1'b0, cfg_pkg::status1_off, 32'h0000_0000, 4'hf);
    check("status1", rd, 32'h0000_0000);
    // every bank one switch on, manual role forced on, address switches 15 with parity off
    @(posedge clock);
    sw1 <= 7'h7f;
    sw2 <= {5'h15, 1'b0, 1'b1, 1'b1};
    repeat (100) @(posedge clock);
    check("early_safe", fx[4], 32'h0000_0000);
    settle();
    wr_ctrl_req(4'hf, 4'hf);
    check("write_en", en, 32'h0000_0000);
    check("effects", fx, 32'h0000_001f);
    check("mezz", mezz, 32'h0000_0085);
    check("geo", {gpar, geo}, 32'h0000_0015);
    bus(1'b0, cfg_pkg::status1_off, 32'h0000_0000, 4'hf);
    check("status1", rd, 32'h0000_00ff);
    bus(1'b0, cfg_pkg::geo_off, 32'h0000_0000, 4'hf);
    check("geo_reg", rd, 32'h0000_0015);
    bus(1'b0, cfg_pkg::switch_raw_off, 32'h0000_0000, 4'hf);
    check("sw_raw", rd, 32'h0000_2bff);
    // bank lock only, manual role forced off, backplane address present
    sw1 <= 7'h04;
    sw2 <= {5'h15, 1'b0, 1'b0, 1'b1};
    bp_valid <= 1'b1;
    bp_geo <= 6'h2a;
    auto_det <= 1'b1;
    settle();
    check("write_en", en, 32'h0000_000e);
    check("effects", fx, 32'h0000_0000);
    check("mezz", mezz, 32'h0000_0064);
    check("geo", {gpar, geo}, 32'h0000_002a);
    bus(1'b0, cfg_pkg::geo_off, 32'h0000_0000, 4'hf);
    check("geo_reg", rd, 32'h0000_012a);
    bus(1'b0, cfg_pkg::status1_off, 32'h0000_0000, 4'hf);
    check("status1", rd, 32'h0000_0002);
    // automatic role: force select has no say
    sw1 <= 7'h00;
    sw2 <= {5'h15, 1'b0, 1'b1, 1'b0};
    auto_det <= 1'b0;
    settle();
    check("role", fx[0], 32'h0000_0000);
    check("write_en", en, 32'h0000_000f);
    auto_det <= 1'b1;
    repeat (5) @(posedge clock);
    check("role", fx[0], 32'h0000_0001);
    // a short bounce must never reach the outputs
    sw1 <= 7'h01;
    repeat (50) @(posedge clock);
    sw1 <= 7'h00;
    seen_on = 1'b0;
    repeat (300) begin
      @(posedge clock);
      seen_on = seen_on | fx[4];
    end
    check("bounce", seen_on, 32'h0000_0000);
    // reset in mid-run returns every effect to its rest value
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    check("rst_effects", {fx, en}, 32'h0000_0000);
    check("rst_geo", {gpar, geo}, 32'h0000_003f);
    check("rst_wait", waitrequest, 32'h0000_0001);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    check("rst_safe", fx[4], 32'h0000_0000);
    end_of_test();
  end
endmodule : board_config_switch_logic_bench
